/* File: core/pcm_i2c_target.sv */
`timescale 1ns/10ps
module pcm_i2c_target (
   // Clock and reset
   input  wire logic       clk,
   input  wire logic       rst_n,
   // Serial pins
   input  wire logic       scl_in,
   input  wire logic       sda_in,
   output logic            sda_oe_n,
   // Register side
   output logic [7:0]      wr_addr,
   output logic [7:0]      wr_data,
   output logic            wr_en,
   output logic [7:0]      rd_addr,
   input  wire logic [7:0] rd_data
);

   logic                scl_s1_r, scl_s2_r, scl_d_r;
   logic                sda_s1_r, sda_s2_r, sda_d_r;
   pcm_pkg::pcm_i2c_st_t st_r, st_nxt;
   logic [7:0]          sh_r, sh_nxt;
   logic [3:0]          cnt_r, cnt_nxt;
   logic [7:0]          ptr_r, ptr_nxt;
   logic [7:0]          wa_r, wa_nxt;
   logic [7:0]          wd_r, wd_nxt;
   logic                rw_r, rw_nxt;
   logic                first_r, first_nxt;
   logic                drv_r, drv_nxt;
   logic                ack_r, ack_nxt;
   logic                wr_r, wr_nxt;
   logic                scl_rise, scl_fall, start_c, stop_c;

   // Two-stage synchronisers, then one delay stage for edges
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         scl_s1_r <= 1'b1;
         scl_s2_r <= 1'b1;
         scl_d_r  <= 1'b1;
         sda_s1_r <= 1'b1;
         sda_s2_r <= 1'b1;
         sda_d_r  <= 1'b1;
      end else begin
         scl_s1_r <= scl_in;
         scl_s2_r <= scl_s1_r;
         scl_d_r  <= scl_s2_r;
         sda_s1_r <= sda_in;
         sda_s2_r <= sda_s1_r;
         sda_d_r  <= sda_s2_r;
      end
   end

   assign scl_rise = scl_s2_r & ~scl_d_r;
   assign scl_fall = ~scl_s2_r & scl_d_r;
   assign start_c  = scl_s2_r & scl_d_r & sda_d_r & ~sda_s2_r;
   assign stop_c   = scl_s2_r & scl_d_r & ~sda_d_r & sda_s2_r;

   always_comb begin
      st_nxt    = st_r;
      sh_nxt    = sh_r;
      cnt_nxt   = cnt_r;
      ptr_nxt   = ptr_r;
      wa_nxt    = wa_r;
      wd_nxt    = wd_r;
      rw_nxt    = rw_r;
      first_nxt = first_r;
      drv_nxt   = drv_r;
      ack_nxt   = ack_r;
      wr_nxt    = 1'b0;
      if (start_c) begin
         st_nxt  = pcm_pkg::ST_ADDR;
         cnt_nxt = 4'h0;
         drv_nxt = 1'b0;
      end else if (stop_c) begin
         st_nxt  = pcm_pkg::ST_IDLE;
         drv_nxt = 1'b0;
      end else begin
         case (st_r)
            pcm_pkg::ST_ADDR: begin
               if (scl_rise) begin
                  sh_nxt  = {sh_r[6:0], sda_s2_r};
                  cnt_nxt = cnt_r + 4'h1;
               end else if (scl_fall && cnt_r == pcm_pkg::BYTE_BITS) begin
                  cnt_nxt = 4'h0;
                  if (sh_r[7:1] == pcm_pkg::DEV_ADDR) begin
                     drv_nxt = 1'b1;
                     rw_nxt  = sh_r[0];
                     st_nxt  = pcm_pkg::ST_ADDR_ACK;
                  end else begin
                     st_nxt = pcm_pkg::ST_IDLE;
                  end
               end
            end
            pcm_pkg::ST_ADDR_ACK: begin
               if (scl_fall) begin
                  if (rw_r) begin
                     sh_nxt  = rd_data;
                     drv_nxt = ~rd_data[7];
                     ptr_nxt = ptr_r + 8'h01;
                     st_nxt  = pcm_pkg::ST_RDATA;
                  end else begin
                     drv_nxt   = 1'b0;
                     first_nxt = 1'b1;
                     st_nxt    = pcm_pkg::ST_WBYTE;
                  end
               end
            end
            pcm_pkg::ST_WBYTE: begin
               if (scl_rise) begin
                  sh_nxt  = {sh_r[6:0], sda_s2_r};
                  cnt_nxt = cnt_r + 4'h1;
               end else if (scl_fall && cnt_r == pcm_pkg::BYTE_BITS) begin
                  drv_nxt = 1'b1;
                  cnt_nxt = 4'h0;
                  st_nxt  = pcm_pkg::ST_WACK;
                  if (first_r) begin
                     ptr_nxt   = sh_r;
                     first_nxt = 1'b0;
                  end else begin
                     wr_nxt  = 1'b1;
                     wa_nxt  = ptr_r;
                     wd_nxt  = sh_r;
                     ptr_nxt = ptr_r + 8'h01;
                  end
               end
            end
            pcm_pkg::ST_WACK: begin
               if (scl_fall) begin
                  drv_nxt = 1'b0;
                  st_nxt  = pcm_pkg::ST_WBYTE;
               end
            end
            pcm_pkg::ST_RDATA: begin
               if (scl_rise) begin
                  cnt_nxt = cnt_r + 4'h1;
               end else if (scl_fall) begin
                  if (cnt_r == pcm_pkg::BYTE_BITS) begin
                     drv_nxt = 1'b0;
                     cnt_nxt = 4'h0;
                     st_nxt  = pcm_pkg::ST_RACK;
                  end else begin
                     sh_nxt  = {sh_r[6:0], 1'b0};
                     drv_nxt = ~sh_r[6];
                  end
               end
            end
            pcm_pkg::ST_RACK: begin
               if (scl_rise) begin
                  ack_nxt = ~sda_s2_r;
               end else if (scl_fall) begin
                  if (ack_r) begin
                     sh_nxt  = rd_data;
                     drv_nxt = ~rd_data[7];
                     ptr_nxt = ptr_r + 8'h01;
                     st_nxt  = pcm_pkg::ST_RDATA;
                  end else begin
                     st_nxt = pcm_pkg::ST_IDLE;
                  end
               end
            end
            default: begin
               st_nxt = pcm_pkg::ST_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         st_r    <= pcm_pkg::ST_IDLE;
         sh_r    <= 8'h00;
         cnt_r   <= 4'h0;
         ptr_r   <= 8'h00;
         wa_r    <= 8'h00;
         wd_r    <= 8'h00;
         rw_r    <= 1'b0;
         first_r <= 1'b0;
         drv_r   <= 1'b0;
         ack_r   <= 1'b0;
         wr_r    <= 1'b0;
      end else begin
         st_r    <= st_nxt;
         sh_r    <= sh_nxt;
         cnt_r   <= cnt_nxt;
         ptr_r   <= ptr_nxt;
         wa_r    <= wa_nxt;
         wd_r    <= wd_nxt;
         rw_r    <= rw_nxt;
         first_r <= first_nxt;
         drv_r   <= drv_nxt;
         ack_r   <= ack_nxt;
         wr_r    <= wr_nxt;
      end
   end

   assign sda_oe_n = ~drv_r;
   assign wr_addr  = wa_r;
   assign wr_data  = wd_r;
   assign wr_en    = wr_r;
   assign rd_addr  = ptr_r;

endmodule // pcm_i2c_target

/* File: core/pcm_pin_cfg_mask_regs.sv */
`timescale 1ns/10ps
module pcm_pin_cfg_mask_regs (
   // Clock and reset
   input  wire logic        CORE_CLK,
   input  wire logic        RST_N,
   // Serial register port
   input  wire logic        SCL_IN,
   input  wire logic        SDA_IN,
   output logic             SDA_OUT,
   output logic             SDA_OE_N,
   // Channel settings held elsewhere
   input  wire logic [3:0]  FUNCTION_SELECT_BIT,
   input  wire logic [3:0]  BREATHING_ENABLE_BIT,
   input  wire logic [3:0]  PIN_DRIVE_LEVEL_BIT,
   input  wire logic [5:0]  HI_GPIO_INPUT,
   input  wire logic        CHANGE_ACK,
   // Channel pins
   input  wire logic [9:0]  CHANNEL_PIN_IN,
   output logic [3:0]       CHANNEL_PIN_OUT,
   output logic [3:0]       CHANNEL_PIN_OE_N,
   output logic [9:0]       CHANNEL_LEVEL,
   // Breathing control
   output logic [3:0]       PERIODIC_FLASH_STYLE,
   output logic [3:0]       RAMP_FADE_STYLE,
   output logic [3:0]       FADE_ON,
   output logic [3:0]       FADE_OFF,
   // Interrupt
   output logic             INTERRUPT_OUTPUT_PIN_N
);

   logic [7:0] wr_addr, wr_data, rd_addr, rd_data;
   logic       wr_en;
   logic [3:0] cfg_r, cfg_nxt;
   logic [5:0] mhi_r, mhi_nxt;
   logic [3:0] mlo_r, mlo_nxt;
   logic [9:0] pin_s1_r, pin_s2_r, pin_d_r;
   logic [2:0] arm_r;
   logic [9:0] pend_r, pend_nxt;
   logic [3:0] drv_d_r;
   logic [3:0] oe_n_r, oe_n_nxt, out_r, flash_r, flash_nxt, ramp_r, ramp_nxt;
   logic [3:0] fon_r, fon_nxt, foff_r, foff_nxt;
   logic       int_n_r, int_n_nxt;
   logic [3:0] lo_in, lo_out, lo_flash, lo_ramp;
   logic [9:0] chg, irq_en;
   logic       first_r;

   pcm_i2c_target u_i2c (
      .clk      (CORE_CLK),
      .rst_n    (RST_N),
      .scl_in   (SCL_IN),
      .sda_in   (SDA_IN),
      .sda_oe_n (SDA_OE_N),
      .wr_addr  (wr_addr),
      .wr_data  (wr_data),
      .wr_en    (wr_en),
      .rd_addr  (rd_addr),
      .rd_data  (rd_data)
   );

   assign SDA_OUT = 1'b0;

   // Per-channel function decode
   genvar g;
   generate
      for (g = 0; g < pcm_pkg::LO_CH; g++) begin : g_lo
         assign lo_in[g]    = FUNCTION_SELECT_BIT[g] & cfg_r[g];
         assign lo_out[g]   = FUNCTION_SELECT_BIT[g] & ~cfg_r[g];
         assign lo_flash[g] = ~FUNCTION_SELECT_BIT[g] & BREATHING_ENABLE_BIT[g]
                              & cfg_r[g];
         assign lo_ramp[g]  = ~FUNCTION_SELECT_BIT[g] & BREATHING_ENABLE_BIT[g]
                              & ~cfg_r[g];
      end
   endgenerate

   // Register writes and readback
   always_comb begin
      cfg_nxt = cfg_r;
      mhi_nxt = mhi_r;
      mlo_nxt = mlo_r;
      if (wr_en) begin
         case (wr_addr)
            pcm_pkg::CFG_LO_OFS:  cfg_nxt = wr_data[3:0];
            pcm_pkg::MASK_HI_OFS: mhi_nxt = wr_data[5:0];
            pcm_pkg::MASK_LO_OFS: mlo_nxt = wr_data[3:0];
            default: ;
         endcase
      end
   end

   always_comb begin
      case (rd_addr)
         pcm_pkg::CFG_LO_OFS:  rd_data = {4'h0, cfg_r};
         pcm_pkg::MASK_HI_OFS: rd_data = {2'h0, mhi_r};
         pcm_pkg::MASK_LO_OFS: rd_data = {4'h0, mlo_r};
         default:              rd_data = pcm_pkg::UNMAPPED_RD;
      endcase
   end

   always_ff @(posedge CORE_CLK or negedge RST_N) begin
      if (!RST_N) begin
         cfg_r <= pcm_pkg::CFG_LO_RST;
         mhi_r <= pcm_pkg::MASK_HI_RST;
         mlo_r <= pcm_pkg::MASK_LO_RST;
      end else begin
         cfg_r <= cfg_nxt;
         mhi_r <= mhi_nxt;
         mlo_r <= mlo_nxt;
      end
   end

   // Pin synchronisers and change detection
   always_ff @(posedge CORE_CLK or negedge RST_N) begin
      if (!RST_N) begin
         pin_s1_r <= 10'h000;
         pin_s2_r <= 10'h000;
         pin_d_r  <= 10'h000;
         arm_r    <= pcm_pkg::ARM_RST;
         first_r  <= 1'b1;
      end else begin
         pin_s1_r <= CHANNEL_PIN_IN;
         pin_s2_r <= pin_s1_r;
         pin_d_r  <= pin_s2_r;
         arm_r    <= {arm_r[1:0], 1'b1};
         first_r  <= 1'b0;
      end
   end

   // No change is seen until the sync chain has filled
   assign chg    = arm_r[2] ? (pin_s2_r ^ pin_d_r) : 10'h000;
   assign irq_en = {HI_GPIO_INPUT & ~mhi_r, lo_in & ~mlo_r};

   // Channel outputs, breathing triggers, interrupt
   always_comb begin
      oe_n_nxt  = ~lo_out;
      flash_nxt = lo_flash;
      ramp_nxt  = lo_ramp;
      fon_nxt   = lo_ramp & PIN_DRIVE_LEVEL_BIT & ~drv_d_r;
      foff_nxt  = lo_ramp & ~PIN_DRIVE_LEVEL_BIT & drv_d_r;
      // A new change wins over an acknowledge in the same cycle
      pend_nxt  = (pend_r & ~{pcm_pkg::ALL_CH{CHANGE_ACK}}) | (chg & irq_en);
      int_n_nxt = ~(|pend_r);
   end

   always_ff @(posedge CORE_CLK or negedge RST_N) begin
      if (!RST_N) begin
         oe_n_r  <= 4'hf;
         out_r   <= 4'h0;
         flash_r <= 4'h0;
         ramp_r  <= 4'h0;
         fon_r   <= 4'h0;
         foff_r  <= 4'h0;
         drv_d_r <= 4'h0;
         pend_r  <= 10'h000;
         int_n_r <= 1'b1;
      end else begin
         oe_n_r  <= oe_n_nxt;
         out_r   <= PIN_DRIVE_LEVEL_BIT;
         flash_r <= flash_nxt;
         ramp_r  <= ramp_nxt;
         fon_r   <= fon_nxt;
         foff_r  <= foff_nxt;
         drv_d_r <= PIN_DRIVE_LEVEL_BIT;
         pend_r  <= pend_nxt;
         int_n_r <= int_n_nxt;
      end
   end

   assign CHANNEL_PIN_OUT        = out_r;
   assign CHANNEL_PIN_OE_N       = oe_n_r;
   assign CHANNEL_LEVEL          = pin_s2_r;
   assign PERIODIC_FLASH_STYLE   = flash_r;
   assign RAMP_FADE_STYLE        = ramp_r;
   assign FADE_ON                = fon_r;
   assign FADE_OFF               = foff_r;
   assign INTERRUPT_OUTPUT_PIN_N = int_n_r;

   property p_dir_out;
      @(posedge CORE_CLK) disable iff (!RST_N)
      (FUNCTION_SELECT_BIT[0] && !cfg_r[0]) |=> !CHANNEL_PIN_OE_N[0];
   endproperty
   a_dir_out: assert property (p_dir_out) else $error("output channel not driven");

   property p_dir_in;
      @(posedge CORE_CLK) disable iff (!RST_N)
      (FUNCTION_SELECT_BIT[3] && cfg_r[3]) |=> CHANNEL_PIN_OE_N[3];
   endproperty
   a_dir_in: assert property (p_dir_in) else $error("input channel driven");

   property p_flash;
      @(posedge CORE_CLK) disable iff (!RST_N)
      (!FUNCTION_SELECT_BIT[1] && BREATHING_ENABLE_BIT[1])
         |=> (PERIODIC_FLASH_STYLE[1] == $past(cfg_r[1])) && (RAMP_FADE_STYLE[1] != $past(cfg_r[1]));
   endproperty
   a_flash: assert property (p_flash) else $error("breathing style wrong");

   property p_cfg_reset;
      @(posedge CORE_CLK) disable iff (!RST_N)
      first_r |-> (rd_data == 8'h00 || rd_addr != pcm_pkg::CFG_LO_OFS) && cfg_r == 4'h0;
   endproperty
   a_cfg_reset: assert property (p_cfg_reset) else $error("config not zero after reset");

   property p_mask_hi;
      @(posedge CORE_CLK) disable iff (!RST_N)
      (wr_en && wr_addr == pcm_pkg::MASK_HI_OFS) |=> mhi_r == $past(wr_data[5:0]);
   endproperty
   a_mask_hi: assert property (p_mask_hi) else $error("high mask write lost");

   property p_mask_lo;
      @(posedge CORE_CLK) disable iff (!RST_N)
      (wr_en && wr_addr == pcm_pkg::MASK_LO_OFS) |=> mlo_r == $past(wr_data[3:0]);
   endproperty
   a_mask_lo: assert property (p_mask_lo) else $error("low mask write lost");

   property p_cfg_read;
      @(posedge CORE_CLK) disable iff (!RST_N)
      (rd_addr == pcm_pkg::CFG_LO_OFS) |-> rd_data == {4'h0, cfg_r};
   endproperty
   a_cfg_read: assert property (p_cfg_read) else $error("config readback wrong");

   property p_fade_on;
      @(posedge CORE_CLK) disable iff (!RST_N)
      (lo_ramp[2] && $rose(PIN_DRIVE_LEVEL_BIT[2])) |=> FADE_ON[2] ##1 !FADE_ON[2];
   endproperty
   a_fade_on: assert property (p_fade_on) else $error("fade-on not pulsed");

   property p_irq_masked;
      @(posedge CORE_CLK) disable iff (!RST_N)
      (pend_r == 10'h000 && (chg & irq_en) == 10'h000) |=> pend_r == 10'h000;
   endproperty
   a_irq_masked: assert property (p_irq_masked) else $error("masked change raised irq");

   property p_irq_raise;
      @(posedge CORE_CLK) disable iff (!RST_N)
      (|(chg & irq_en)) |=> ##1 !INTERRUPT_OUTPUT_PIN_N;
   endproperty
   a_irq_raise: assert property (p_irq_raise) else $error("enabled change missed");

endmodule // pcm_pin_cfg_mask_regs

/* File: core/pcm_pkg.sv */
package pcm_pkg;

   // Register offsets on the serial port
   localparam logic [7:0] CFG_LO_OFS  = 8'h05;
   localparam logic [7:0] MASK_HI_OFS = 8'h06;
   localparam logic [7:0] MASK_LO_OFS = 8'h07;

   // Channel counts
   localparam int LO_CH = 4;
   localparam int HI_CH = 6;
   localparam int ALL_CH = 10;

   // Values after reset, and the value read at unmapped offsets
   localparam logic [3:0] CFG_LO_RST  = 4'h0;
   localparam logic [5:0] MASK_HI_RST = 6'h00;
   localparam logic [3:0] MASK_LO_RST = 4'h0;
   localparam logic [7:0] UNMAPPED_RD = 8'h00;

   // Serial target address, arbitrary value
   localparam logic [6:0] DEV_ADDR = 7'h2c;

   // Bits per serial byte
   localparam logic [3:0] BYTE_BITS = 4'h8;

   // Reset value of the arm shift register; pin change detection is armed 3 cycles after reset
   localparam logic [2:0] ARM_RST = 3'h0;

   typedef enum {
      ST_IDLE,
      ST_ADDR,
      ST_ADDR_ACK,
      ST_WBYTE,
      ST_WACK,
      ST_RDATA,
      ST_RACK
   } pcm_i2c_st_t;

endpackage

/* File: verif/pcm_host_model.sv */
`timescale 1ns/10ps
module pcm_host_model (
   // Clock
   input  wire logic clk,
   // Serial pins
   input  wire logic dev_oe_n,
   output logic      scl,
   output logic      sda
);
   logic host_low;

   // Open-drain line with pull-up
   assign sda = ~host_low & dev_oe_n;

   initial begin
      scl      = 1'b1;
      host_low = 1'b0;
   end

   task automatic tick(input int n);
      repeat (n) @(posedge clk);
   endtask

   // Data moves only while the clock line is low
   task automatic put_bit(input logic b);
      tick(2);
      host_low <= ~b;
      tick(6);
      scl <= 1'b1;
      tick(8);
      scl <= 1'b0;
   endtask

   task automatic get_bit(output logic b);
      tick(2);
      host_low <= 1'b0;
      tick(6);
      scl <= 1'b1;
      tick(4);
      b = sda;
      tick(4);
      scl <= 1'b0;
   endtask

   task automatic start_cond();
      tick(2);
      host_low <= 1'b0;
      tick(6);
      scl <= 1'b1;
      tick(8);
      host_low <= 1'b1;
      tick(8);
      scl <= 1'b0;
   endtask

   task automatic stop_cond();
      tick(2);
      host_low <= 1'b1;
      tick(6);
      scl <= 1'b1;
      tick(8);
      host_low <= 1'b0;
      tick(8);
   endtask

   task automatic send_byte(input logic [7:0] b, output logic ack);
      logic a;
      for (int i = 7; i >= 0; i--) begin
         put_bit(b[i]);
      end
      get_bit(a);
      ack = ~a;
   endtask

   task automatic write_regs(input logic [6:0] dev, input logic [7:0] ofs, input int n,
                             input logic [7:0] d0, input logic [7:0] d1, output logic acked);
      logic a;
      start_cond();
      send_byte({dev, 1'b0}, acked);
      send_byte(ofs, a);
      acked = acked & a;
      send_byte(d0, a);
      acked = acked & a;
      if (n > 1) begin
         send_byte(d1, a);
         acked = acked & a;
      end
      stop_cond();
   endtask

   task automatic read_reg(input logic [7:0] ofs, output logic [7:0] d);
      logic a;
      start_cond();
      send_byte({pcm_pkg::DEV_ADDR, 1'b0}, a);
      send_byte(ofs, a);
      start_cond();
      send_byte({pcm_pkg::DEV_ADDR, 1'b1}, a);
      for (int i = 7; i >= 0; i--) begin
         get_bit(d[i]);
      end
      put_bit(1'b1);
      stop_cond();
   endtask
endmodule // pcm_host_model

/* File: verif/pcm_pin_cfg_mask_regs_bench.sv */
`timescale 1ns/10ps
module pcm_pin_cfg_mask_regs_bench;
   localparam int LIMIT = 60000;
   logic        clk, rst_n, scl, sda, sda_out, sda_oe_n, ack, irq_n, ok;
   logic [3:0]  fs, be, drv, pin_out, pin_oe_n, flash, ramp, f_on, f_off, old, nv, on_s, off_s;
   logic [5:0]  hi_in;
   logic [9:0]  pin_ext, pin_wire, level;
   logic [7:0]  rd, cfg, mhi, mlo;
   logic [31:0] seed;
   int          fails, n_compared, cycles, j;

   // Low channels set as outputs drive their own pins
   assign pin_wire = {pin_ext[9:4], (~pin_oe_n & pin_out) | (pin_oe_n & pin_ext[3:0])};

   pcm_pin_cfg_mask_regs i_pcm_pin_cfg_mask_regs (
      .CORE_CLK (clk), .RST_N (rst_n), .SCL_IN (scl), .SDA_IN (sda), .SDA_OUT (sda_out),
      .SDA_OE_N (sda_oe_n), .FUNCTION_SELECT_BIT (fs), .BREATHING_ENABLE_BIT (be),
      .PIN_DRIVE_LEVEL_BIT (drv), .HI_GPIO_INPUT (hi_in), .CHANGE_ACK (ack),
      .CHANNEL_PIN_IN (pin_wire), .CHANNEL_PIN_OUT (pin_out), .CHANNEL_PIN_OE_N (pin_oe_n),
      .CHANNEL_LEVEL (level), .PERIODIC_FLASH_STYLE (flash), .RAMP_FADE_STYLE (ramp),
      .FADE_ON (f_on), .FADE_OFF (f_off), .INTERRUPT_OUTPUT_PIN_N (irq_n)
   );

   pcm_host_model i_pcm_host_model (.clk (clk), .dev_oe_n (sda_oe_n), .scl (scl), .sda (sda));

   initial begin
      clk = 1'b0;
   end
   always #5 clk = ~clk;

   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction

   function automatic logic irq_exp(int k, logic [3:0] f, logic [3:0] c, logic [5:0] h,
                                    logic [7:0] ml, logic [7:0] mh);
      logic [9:0] is_in;
      logic [9:0] msk;
      is_in = {h, f & c};
      msk   = {mh[5:0], ml[3:0]};
      return ~(is_in[k] & ~msk[k]);
   endfunction

   task automatic check(input logic [9:0] seen, input logic [9:0] exp, input string what);
      n_compared++;
      if (seen !== exp) begin
         fails++;
         $display("unexpected at %0t: %s seen %h expected %h", $time, what, seen, exp);
      end
   endtask

   task automatic complete_run();
      $display("compared %0d, mismatches %0d", n_compared, fails);
      if (fails == 0 && n_compared > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == LIMIT) begin
         fails++;
         complete_run();
      end
   end

   initial begin
      seed = 32'h0000852f;
      fails = 0;
      n_compared = 0;
      rst_n = 1'b0;
      {fs, be, drv, hi_in, ack, pin_ext} = '0;
      repeat (5) @(posedge clk);
      rst_n <= 1'b1;
      for (int a = 5; a < 9; a++) begin
         i_pcm_host_model.read_reg(8'(a), rd);
         check(rd, 10'h000, "reset or unmapped value");
      end
      i_pcm_host_model.write_regs(pcm_pkg::DEV_ADDR ^ 7'h01, pcm_pkg::MASK_LO_OFS, 1,
                                  8'hff, 8'h00, ok);
      check(ok, 1'b0, "foreign address answered");
      check(sda_out, 1'b0, "data line drive level");
      i_pcm_host_model.read_reg(pcm_pkg::MASK_LO_OFS, rd);
      check(rd, 10'h000, "mask changed by foreign write");
      // Direction and breathing style per function
      for (int k = 0; k < 4; k++) begin
         cfg = (k == 0) ? 8'hff : (k == 1) ? 8'h00 : 8'(rnd());
         i_pcm_host_model.write_regs(pcm_pkg::DEV_ADDR, pcm_pkg::CFG_LO_OFS, 1, cfg, 8'h00, ok);
         i_pcm_host_model.read_reg(pcm_pkg::CFG_LO_OFS, rd);
         check(rd, {6'h00, cfg[3:0]}, "config readback");
         for (int m = 0; m < 8; m++) begin
            @(posedge clk);
            fs <= 4'(rnd());
            be <= 4'(rnd());
            drv <= 4'(rnd());
            repeat (3) @(posedge clk);
            #1;
            check(pin_oe_n, 4'(~(fs & ~cfg[3:0])), "direction");
            check(pin_out, drv, "drive level");
            check(flash, ~fs & be & cfg[3:0], "flash style");
            check(ramp, ~fs & be & ~cfg[3:0], "ramp style");
         end
      end
      // Fade triggers only in ramp style
      @(posedge clk);
      fs <= 4'h0;
      be <= 4'hf;
      drv <= 4'h0;
      old = 4'h0;
      for (int s = 0; s < 2; s++) begin
         cfg = (s == 0) ? 8'h00 : 8'h0f;
         i_pcm_host_model.write_regs(pcm_pkg::DEV_ADDR, pcm_pkg::CFG_LO_OFS, 1, cfg, 8'h00, ok);
         for (int m = 0; m < 6; m++) begin
            nv = (m == 0) ? 4'hf : (m == 1) ? 4'h0 : 4'(rnd());
            @(posedge clk);
            drv <= nv;
            on_s = 4'h0;
            off_s = 4'h0;
            repeat (4) begin
               @(posedge clk);
               #1;
               on_s |= f_on;
               off_s |= f_off;
            end
            check(on_s, (s == 0) ? nv & ~old : 4'h0, "fade on");
            check(off_s, (s == 0) ? ~nv & old : 4'h0, "fade off");
            check(f_on | f_off, 4'h0, "fade pulse length");
            old = nv;
         end
      end
      // Interrupt enables, active low, for inputs only
      for (int g = 0; g < 6; g++) begin
         mhi = (g == 0) ? 8'h00 : (g == 1) ? 8'hff : 8'(rnd());
         mlo = (g == 0) ? 8'h00 : (g == 1) ? 8'hff : 8'(rnd());
         i_pcm_host_model.write_regs(pcm_pkg::DEV_ADDR, pcm_pkg::MASK_HI_OFS, 2, mhi, mlo, ok);
         i_pcm_host_model.read_reg(pcm_pkg::MASK_LO_OFS, rd);
         check(rd, {6'h00, mlo[3:0]}, "low mask");
         i_pcm_host_model.read_reg(pcm_pkg::MASK_HI_OFS, rd);
         check(rd, {4'h0, mhi[5:0]}, "high mask");
         for (int m = 0; m < 5; m++) begin
            @(posedge clk);
            fs <= 4'(rnd());
            be <= 4'(rnd());
            hi_in <= 6'(rnd());
            repeat (10) @(posedge clk);
            ack <= 1'b1;
            @(posedge clk);
            ack <= 1'b0;
            repeat (3) @(posedge clk);
            #1;
            check(irq_n, 1'b1, "interrupt after clear");
            @(posedge clk);
            j = int'(rnd() % 10);
            pin_ext[j] <= ~pin_ext[j];
            repeat (8) @(posedge clk);
            #1;
            check(irq_n, irq_exp(j, fs, cfg[3:0], hi_in, mlo, mhi), "interrupt");
            check(level, pin_ext, "synchronised level");
         end
      end
      // Second reset in mid-run returns all three registers to zero
      @(posedge clk);
      rst_n <= 1'b0;
      repeat (3) @(posedge clk);
      rst_n <= 1'b1;
      for (int a = 5; a < 8; a++) begin
         i_pcm_host_model.read_reg(8'(a), rd);
         check(rd, 10'h000, "value after second reset");
      end
      complete_run();
   end
endmodule // pcm_pin_cfg_mask_regs_bench
